// >>> image_sensor_channel_sequencer.sv
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none
// How it works
// - four modes: single/triple, CCD/CIS
// - single bit set: one channel processed
// - select bits pick input; 01 is blue
// - single mode: multiplexer stays put
// - CCD: reset and video samples subtracted
// - format bit: parallel or byte output
// - CIS: one sample on reset clock fall
// - triple: all three sampled together
// - triple: advance on data clock fall
// - order bit: forward or reverse order
// - reset clock fall: back to first
// - per channel 10-bit offset correction
// - one shared 14-bit converter
// - CCD clamp enable drives biasing
// - demux: high byte rise, low fall
// - 8-bit config at zero, resets zero
module image_sensor_channel_sequencer #(
  parameter int RES_W = sequencer_pkg::RES_W,
  parameter int OFF_W = sequencer_pkg::OFF_W
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  // register bus
  input  wire sequencer_pkg::axi_req_t axi_req,
  output sequencer_pkg::axi_rsp_t      axi_rsp,
  // timing pins from the sensor side
  input  wire logic                    reset_sample_clock,
  input  wire logic                    data_sample_clock,
  input  wire logic                    converter_clock,
  input  wire logic                    clamp_enable,
  // digitised input levels
  input  wire logic [RES_W-1:0]        red_input,
  input  wire logic [RES_W-1:0]        green_input,
  input  wire logic [RES_W-1:0]        blue_input,
  input  wire logic [RES_W-1:0]        common_reference_input,
  // results
  output logic                         clamp_active,
  output logic [RES_W-1:0]             data_out,
  output logic                         result_valid,
  output sequencer_pkg::channel_t      result_channel
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]                      cfg;     // software setting
    logic [7:0]                      act;     // setting in force
    logic [2:0][OFF_W-1:0]           off;     // offset codes
    logic [1:0]                      rs_s;    // synchronisers
    logic [1:0]                      ds_s;
    logic [1:0]                      cc_s;
    logic [1:0]                      cl_s;
    logic                            rs_d;    // edge history
    logic                            ds_d;
    logic                            cc_d;
    logic [3:0][RES_W-1:0]           in_a;    // level sync stage 1
    logic [3:0][RES_W-1:0]           in_b;    // level sync stage 2
    logic [2:0][RES_W-1:0]           rst_lvl; // reset level per stage
    logic [2:0][RES_W:0]             held;    // signed stage output
    sequencer_pkg::channel_t         sel;     // multiplexer
    sequencer_pkg::channel_t         tag;
    logic [RES_W-1:0]                res;
    logic [RES_W-1:0]                dout;
    logic                            rv;
    logic                            clamp;
    logic                            aw_got;
    logic                            w_got;
    logic [sequencer_pkg::ADDR_W-1:0] awaddr;
    logic [31:0]                     wdata;
    logic [3:0]                      wstrb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [31:0]                     rdata;
    logic [1:0]                      rresp;
  } state_t;

  state_t     s_reg;   // registered state
  state_t     s_next;  // next state
  logic       rs_fall; // reset-sample clock fell
  logic       ds_fall; // data-sample clock fell
  logic       cc_rise; // converter clock rose
  logic       cc_fall; // converter clock fell
  logic [7:0] eff;     // setting seen at this edge
  logic       awready;
  logic       wready;

  // edges come from the second flop only
  assign rs_fall = s_reg.rs_d & ~s_reg.rs_s[1];
  assign ds_fall = s_reg.ds_d & ~s_reg.ds_s[1];
  assign cc_rise = ~s_reg.cc_d & s_reg.cc_s[1];
  assign cc_fall = s_reg.cc_d & ~s_reg.cc_s[1];
  // a new setting is taken at the fall itself
  assign eff     = rs_fall ? s_reg.cfg : s_reg.act;
  assign awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign wready  = ~s_reg.w_got & ~s_reg.bvalid;

  // ****************************************
  // channel helpers
  // ****************************************
  // select bits {hi,lo}: 00 red, 10 green, 01 blue, 11 red
  function automatic sequencer_pkg::channel_t pick_ch(input logic [7:0] c);
    logic [1:0] v;
    v = {c[sequencer_pkg::SEL_HI_BIT], c[sequencer_pkg::SEL_LO_BIT]};
    case (v)
      2'h1:    pick_ch = sequencer_pkg::CH_BLUE;
      2'h2:    pick_ch = sequencer_pkg::CH_GREEN;
      default: pick_ch = sequencer_pkg::CH_RED;
    endcase
  endfunction : pick_ch

  // forward r>g>b, reverse b>g>r, wrapping
  function automatic sequencer_pkg::channel_t step_ch(
    input sequencer_pkg::channel_t c, input logic rev);
    case (c)
      sequencer_pkg::CH_RED:   step_ch = rev ? sequencer_pkg::CH_BLUE : sequencer_pkg::CH_GREEN;
      sequencer_pkg::CH_GREEN: step_ch = rev ? sequencer_pkg::CH_RED : sequencer_pkg::CH_BLUE;
      default:                 step_ch = rev ? sequencer_pkg::CH_GREEN : sequencer_pkg::CH_RED;
    endcase
  endfunction : step_ch

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic signed [RES_W+1:0] sum;
    logic [3:0]              idx;
    logic [1:0]              k;
    sum    = '0;
    idx    = '0;
    k      = '0;
    s_next = s_reg;
    // pins: two flops before use
    s_next.rs_s = {s_reg.rs_s[0], reset_sample_clock};
    s_next.ds_s = {s_reg.ds_s[0], data_sample_clock};
    s_next.cc_s = {s_reg.cc_s[0], converter_clock};
    s_next.cl_s = {s_reg.cl_s[0], clamp_enable};
    s_next.rs_d = s_reg.rs_s[1];
    s_next.ds_d = s_reg.ds_s[1];
    s_next.cc_d = s_reg.cc_s[1];
    s_next.in_a = {common_reference_input, blue_input, green_input, red_input};
    s_next.in_b = s_reg.in_a;
    // bias only in ccd modes, while reset clock high
    s_next.clamp = s_reg.cl_s[1] & s_reg.rs_s[1] & ~s_reg.act[sequencer_pkg::CIS_BIT];
    if (rs_fall) begin
      s_next.act = s_reg.cfg;
    end
    // three stages always run; single mode just ignores two
    for (int i = 0; i < 3; i++) begin
      if (rs_fall && eff[sequencer_pkg::CIS_BIT]) begin
        // contact sensor: input minus common reference
        s_next.held[i] = {1'b0, s_reg.in_b[i]} - {1'b0, s_reg.in_b[3]};
      end else if (rs_fall) begin
        s_next.rst_lvl[i] = s_reg.in_b[i];
      end
      // data clock is grounded in cis, so no second sample
      if (ds_fall && !s_reg.act[sequencer_pkg::CIS_BIT]) begin
        s_next.held[i] = {1'b0, s_reg.rst_lvl[i]} - {1'b0, s_reg.in_b[i]};
      end
    end
    // multiplexer: the reset fall wins over a data fall
    if (rs_fall && eff[sequencer_pkg::SINGLE_BIT]) begin
      s_next.sel = pick_ch(eff);
    end else if (rs_fall) begin
      s_next.sel = eff[sequencer_pkg::ORDER_BIT] ?
                   sequencer_pkg::CH_BLUE : sequencer_pkg::CH_RED;
    end else if (ds_fall && !s_reg.act[sequencer_pkg::SINGLE_BIT]) begin
      s_next.sel = step_ch(s_reg.sel, s_reg.act[sequencer_pkg::ORDER_BIT]);
    end
    // conversion at each converter clock rise
    s_next.rv = cc_rise;
    if (cc_rise) begin
      sum = (RES_W+2)'($signed(s_reg.held[s_reg.sel]))
          + (RES_W+2)'($signed(s_reg.off[s_reg.sel]));
      if (sum < 0) begin
        s_next.res = '0;
      end else if (sum > $signed({2'b00, {RES_W{1'b1}}})) begin
        s_next.res = '1;
      end else begin
        s_next.res = sum[RES_W-1:0];
      end
      s_next.tag = s_reg.sel;
      if (s_reg.cfg[sequencer_pkg::FORMAT_BIT]) begin
        s_next.dout = {s_next.res[RES_W-1-:8], {(RES_W-8){1'b0}}};
      end else begin
        s_next.dout = s_next.res;
      end
    end
    // low bits left aligned, zero filled
    if (cc_fall && s_reg.cfg[sequencer_pkg::FORMAT_BIT]) begin
      s_next.dout = {s_reg.res[RES_W-9:0], 8'h00};
    end
    // write address and data, either order
    if (axi_req.awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      idx            = s_reg.awaddr[sequencer_pkg::ADDR_W-1:2];
      k              = 2'(idx - 4'h1);
      s_next.aw_got  = 1'b0;
      s_next.w_got   = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = sequencer_pkg::RESP_OKAY;
      if (idx == 4'(sequencer_pkg::CFG_IDX)) begin
        if (s_reg.wstrb[0]) s_next.cfg = s_reg.wdata[7:0];
      end else if (idx >= 4'(sequencer_pkg::RED_OFF_IDX) &&
                   idx <= 4'(sequencer_pkg::BLU_OFF_IDX)) begin
        if (s_reg.wstrb[0]) s_next.off[k][7:0] = s_reg.wdata[7:0];
        if (s_reg.wstrb[1]) s_next.off[k][OFF_W-1:8] = s_reg.wdata[OFF_W-1:8];
      end else if (idx != 4'(sequencer_pkg::STATUS_IDX)) begin
        s_next.bresp = sequencer_pkg::RESP_SLVERR; // unmapped
      end
    end else if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    // read: one outstanding, answered next cycle
    if (axi_req.arvalid && !s_reg.rvalid) begin
      idx          = axi_req.araddr[sequencer_pkg::ADDR_W-1:2];
      k            = 2'(idx - 4'h1);
      s_next.rvalid = 1'b1;
      s_next.rresp  = sequencer_pkg::RESP_OKAY;
      s_next.rdata  = '0;
      if (idx == 4'(sequencer_pkg::CFG_IDX)) begin
        s_next.rdata[7:0] = s_reg.cfg;
      end else if (idx >= 4'(sequencer_pkg::RED_OFF_IDX) &&
                   idx <= 4'(sequencer_pkg::BLU_OFF_IDX)) begin
        s_next.rdata[OFF_W-1:0] = s_reg.off[k];
      end else if (idx == 4'(sequencer_pkg::STATUS_IDX)) begin
        s_next.rdata[11:0] = {s_reg.tag, s_reg.sel, s_reg.act};
      end else begin
        s_next.rresp = sequencer_pkg::RESP_SLVERR;
      end
    end else if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg     <= '0;
      s_reg.cfg <= sequencer_pkg::CFG_RESET;
      s_reg.act <= sequencer_pkg::CFG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign axi_rsp.awready = awready;
  assign axi_rsp.wready  = wready;
  assign axi_rsp.bvalid  = s_reg.bvalid;
  assign axi_rsp.bresp   = s_reg.bresp;
  assign axi_rsp.arready = ~s_reg.rvalid;
  assign axi_rsp.rvalid  = s_reg.rvalid;
  assign axi_rsp.rdata   = s_reg.rdata;
  assign axi_rsp.rresp   = s_reg.rresp;
  assign clamp_active    = s_reg.clamp;
  assign data_out        = s_reg.dout;
  assign result_valid    = s_reg.rv;
  assign result_channel  = s_reg.tag;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_conv;
    cc_rise ##1 result_valid;
  endsequence
  property p_first_ch;
    rs_fall && !s_reg.cfg[sequencer_pkg::SINGLE_BIT] |=>
      s_reg.sel == ($past(s_reg.cfg[sequencer_pkg::ORDER_BIT]) ?
                    sequencer_pkg::CH_BLUE : sequencer_pkg::CH_RED);
  endproperty
  a_first_ch: assert property (p_first_ch) else $error("wrong first channel");
  property p_step;
    ds_fall && !rs_fall && !s_reg.act[sequencer_pkg::SINGLE_BIT] |=>
      s_reg.sel == step_ch($past(s_reg.sel), s_reg.act[sequencer_pkg::ORDER_BIT]);
  endproperty
  a_step: assert property (p_step) else $error("mux did not advance");
  property p_hold;
    !rs_fall && s_reg.act[sequencer_pkg::SINGLE_BIT] |=> $stable(s_reg.sel);
  endproperty
  a_hold: assert property (p_hold) else $error("single mux moved");
  property p_blue;
    rs_fall && s_reg.cfg[5:3] == 3'b011 |=> s_reg.sel == sequencer_pkg::CH_BLUE;
  endproperty
  a_blue: assert property (p_blue) else $error("blue select failed");
  property p_shadow;
    !rs_fall |=> $stable(s_reg.act);
  endproperty
  a_shadow: assert property (p_shadow) else $error("setting changed mid line");
  property p_low_byte;
    cc_fall && s_reg.cfg[sequencer_pkg::FORMAT_BIT] |=>
      data_out == {$past(s_reg.res[RES_W-9:0]), 8'h00};
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("bad low byte");
  // only parallel format is held to the full result; demux has its own check
  property p_normal;
    cc_rise && !s_reg.cfg[sequencer_pkg::FORMAT_BIT] |->
      s_conv and (1'b1 ##1 data_out == s_reg.res);
  endproperty
  a_normal: assert property (p_normal) else $error("bad parallel out");
  property p_tag;
    cc_rise |=> result_channel == $past(s_reg.sel) ##1 result_valid == 1'b0;
  endproperty
  a_tag: assert property (p_tag) else $error("result tag wrong");
endmodule : image_sensor_channel_sequencer
`default_nettype wire

// >>> sensor_timing_model.sv
`default_nettype none
// ****************************************
// sensor and timing generator model
// ****************************************
module sensor_timing_model (
  // clock and mode
  input  wire logic             sys_clk,
  input  wire logic             cis,
  // levels offered per channel, index 0 red, 1 green, 2 blue
  input  wire logic [2:0][13:0] rst_lvl,
  input  wire logic [2:0][13:0] vid_lvl,
  input  wire logic [13:0]      ref_lvl,
  // timing pins
  output var  logic             reset_sample_clock,
  output var  logic             data_sample_clock,
  output var  logic             converter_clock,
  // sensor levels
  output var  logic [13:0]      red_input,
  output var  logic [13:0]      green_input,
  output var  logic [13:0]      blue_input,
  output var  logic [13:0]      common_reference_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // all pins quiet until a step is asked for
  initial begin
    reset_sample_clock     = 1'b0;
    data_sample_clock      = 1'b0;
    converter_clock        = 1'b0;
    red_input              = 14'h0000;
    green_input            = 14'h0000;
    blue_input             = 14'h0000;
    common_reference_input = 14'h0000;
  end
  // six clocks per step: the pins pass a synchroniser, so faster edges are lost
  task automatic settle();
    repeat (6) @(posedge sys_clk);
  endtask : settle
  // levels change together with the pin that samples them
  task automatic drive_lvl(input logic [2:0][13:0] v);
    red_input              <= v[0];
    green_input            <= v[1];
    blue_input             <= v[2];
    common_reference_input <= ref_lvl;
  endtask : drive_lvl
  // reset pulse, converter clock left as the caller holds it
  task automatic rs_rise();
    drive_lvl(rst_lvl);
    reset_sample_clock <= 1'b1;
    settle();
  endtask : rs_rise
  task automatic rs_fall();
    reset_sample_clock <= 1'b0;
    settle();
  endtask : rs_fall
  // data pulse only outside contact mode, always inside converter low phase
  task automatic ds_pulse();
    if (cis) return;
    drive_lvl(vid_lvl);
    data_sample_clock <= 1'b1;
    settle();
    data_sample_clock <= 1'b0;
    settle();
  endtask : ds_pulse
  task automatic conv_up();
    converter_clock <= 1'b1;
    settle();
  endtask : conv_up
  task automatic conv_dn();
    converter_clock <= 1'b0;
    settle();
  endtask : conv_dn
endmodule : sensor_timing_model
`default_nettype wire

// >>> sequencer_pkg.sv
`default_nettype none
package sequencer_pkg;
  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam int unsigned CFG_IDX     = 0;  // mode configuration
  localparam int unsigned RED_OFF_IDX = 1;  // red offset code
  localparam int unsigned GRN_OFF_IDX = 2;  // green offset code
  localparam int unsigned BLU_OFF_IDX = 3;  // blue offset code
  localparam int unsigned STATUS_IDX  = 8;  // live sequencer state
  localparam int unsigned ADDR_W      = 6;  // byte address width
  // ****************************************
  // configuration field positions and reset
  // ****************************************
  localparam int unsigned CIS_BIT     = 2;  // 1 = contact sensor
  localparam int unsigned SINGLE_BIT  = 3;  // single_channel_bit
  localparam int unsigned SEL_LO_BIT  = 4;  // channel_select_low_bit
  localparam int unsigned SEL_HI_BIT  = 5;  // channel_select_high_bit
  localparam int unsigned ORDER_BIT   = 6;  // sequence_order_bit
  localparam int unsigned FORMAT_BIT  = 7;  // output_format_bit
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned RES_W = 14;  // converter result
  localparam int unsigned OFF_W = 10;  // offset correction code
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // multiplexer channels
  typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} channel_t;
  // axi4-lite master to slave
  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;
  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage : sequencer_pkg
`default_nettype wire

// >>> test_image_sensor_channel_sequencer.sv
`default_nettype none
module test_image_sensor_channel_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and stimulus levels
  // ****************************************
  localparam sequencer_pkg::channel_t R = sequencer_pkg::CH_RED;
  localparam sequencer_pkg::channel_t G = sequencer_pkg::CH_GREEN;
  localparam sequencer_pkg::channel_t B = sequencer_pkg::CH_BLUE;
  localparam logic [2:0][13:0] RST = {14'h3800, 14'h2800, 14'h3000};  // blue, green, red
  localparam logic [2:0][13:0] VID = {14'h0A00, 14'h0400, 14'h1000};
  localparam logic [13:0]      REF = 14'h0100;
  logic                    sys_clk      = 1'b0;
  logic                    reset_n      = 1'b0;
  logic                    clamp_enable = 1'b0;
  logic                    cis          = 1'b0;
  sequencer_pkg::axi_req_t req          = '0;
  sequencer_pkg::axi_rsp_t rsp;
  logic                    reset_sample_clock, data_sample_clock, converter_clock;
  logic [13:0]             red_input, green_input, blue_input, common_reference_input;
  logic                    clamp_active, result_valid;
  logic [13:0]             data_out, last_val;
  sequencer_pkg::channel_t result_channel, last_ch;
  int                      err_total = 0;
  int                      cmp_count = 0;
  int                      n_valid   = 0;
  int                      off [3]   = '{0, 0, 0};  // offsets as programmed
  logic                    ccd, demux, early;       // mode as the bench set it
  logic [7:0]              prev_cfg  = 8'h00;
  logic [31:0]             rd;
  logic [1:0]              rr;
  always #4 sys_clk = ~sys_clk;
  image_sensor_channel_sequencer DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .axi_req(req), .axi_rsp(rsp),
    .reset_sample_clock(reset_sample_clock), .data_sample_clock(data_sample_clock),
    .converter_clock(converter_clock), .clamp_enable(clamp_enable),
    .red_input(red_input), .green_input(green_input), .blue_input(blue_input),
    .common_reference_input(common_reference_input), .clamp_active(clamp_active),
    .data_out(data_out), .result_valid(result_valid), .result_channel(result_channel)
  );
  sensor_timing_model PARTNER (
    .sys_clk(sys_clk), .cis(cis), .rst_lvl(RST), .vid_lvl(VID), .ref_lvl(REF),
    .reset_sample_clock(reset_sample_clock), .data_sample_clock(data_sample_clock),
    .converter_clock(converter_clock), .red_input(red_input), .green_input(green_input),
    .blue_input(blue_input), .common_reference_input(common_reference_input)
  );
  // capture every conversion pulse with its payload
  always @(posedge sys_clk) begin
    if (result_valid === 1'b1) begin
      n_valid  <= n_valid + 1;
      last_val <= data_out;
      last_ch  <= result_channel;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    // no cycle limit here: only the watchdog ends a stuck wait
    forever begin
      @(posedge sys_clk);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask : bus_write
  task automatic bus_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask : bus_read
  // difference or single sample plus offset, clipped to the converter range
  function automatic logic [13:0] expect_val(input int ch);
    int v;
    v = int'(RST[ch]) - (ccd ? int'(VID[ch]) : int'(REF)) + off[ch];
    if (v < 0) v = 0;
    if (v > 16383) v = 16383;
    return v[13:0];
  endfunction : expect_val
  // the mode in force only changes at the reset fall, so a priming pixel is not checked
  task automatic clamp_step(input logic chk);
    PARTNER.rs_rise();
    if (chk) check(32'(clamp_active), 32'(ccd));
  endtask : clamp_step
  // one pixel: three conversions; early puts the reset rise inside converter high
  task automatic pixel(input sequencer_pkg::channel_t c [3], input logic chk);
    logic [13:0] e;
    int          v0;
    for (int i = 0; i < 3; i++) begin
      e = expect_val(int'(c[i]));
      if (i == 0 && !early) clamp_step(chk);
      if (i == 0 && !early) PARTNER.rs_fall();
      v0 = n_valid;
      PARTNER.conv_up();
      if (chk) begin
        check(32'(n_valid - v0), 32'h1);
        check(32'(last_ch), 32'(c[i]));
        check(32'(last_val), 32'(demux ? {e[13:6], 6'h00} : e));
      end
      if (i == 0 && early) clamp_step(chk);
      PARTNER.conv_dn();
      if (chk && demux) check(32'(data_out), 32'({e[5:0], 8'h00}));
      if (i == 0 && early) PARTNER.rs_fall();
      PARTNER.ds_pulse();
    end
  endtask : pixel
  // new setting; format bit applies at once, the rest stays old in force until the next reset-sample fall
  task automatic run_mode(input logic [7:0] cfg, input sequencer_pkg::channel_t c [3]);
    bus_write(6'h00, {24'h0, cfg}, rr);
    check(32'(rr), 32'(sequencer_pkg::RESP_OKAY));
    bus_read(6'h20, rd, rr);
    check(32'(rd[6:0]), 32'(prev_cfg[6:0]));
    ccd   = ~cfg[sequencer_pkg::CIS_BIT];
    demux = cfg[sequencer_pkg::FORMAT_BIT];
    early = ccd & cfg[sequencer_pkg::SINGLE_BIT];
    cis   <= ~ccd;
    pixel(c, 1'b0);
    pixel(c, 1'b1);
    prev_cfg = cfg;
  endtask : run_mode
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n      <= 1'b1;
    bus_read(6'h00, rd, rr);
    check(rd, 32'h0);
    bus_read(6'h10, rd, rr);
    check(32'(rr), 32'(sequencer_pkg::RESP_SLVERR));
    bus_write(6'h04, 32'h0000_03FB, rr);
    off[0] = -5;
    bus_write(6'h0C, 32'h0000_0007, rr);
    off[2] = 7;
    bus_read(6'h04, rd, rr);
    check(rd, 32'h0000_03FB);
    // ccd mode but clamp input low: no biasing
    PARTNER.rs_rise();
    check(32'(clamp_active), 32'h0);
    clamp_enable <= 1'b1;
    PARTNER.rs_fall();
    run_mode(8'h00, '{R, G, B});
    run_mode(8'h40, '{B, G, R});
    run_mode(8'hC0, '{B, G, R});
    run_mode(8'h28, '{G, G, G});
    run_mode(8'h1C, '{B, B, B});
    run_mode(8'h04, '{R, R, R});
    tally_and_finish();
  end
  // hang guard, about twenty times the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule : test_image_sensor_channel_sequencer
`default_nettype wire
